/* File: watchdog_pkg.sv */
// Summary of operation
// [R1] The window watchdog is a 14-bit down-counter that counts while running and reloads on each valid refresh.
// [R2] A window watchdog underflow requests a chip reset when the reset response is selected.
// [R3] A window watchdog underflow may instead raise a non-maskable interrupt or an ordinary interrupt.
// [R4] The window watchdog only accepts a refresh inside a configurable count window; outside it is a runaway.
// [R5] Software refreshes the independent watchdog often enough that its 14-bit counter never underflows.
// [R6] An independent watchdog underflow gives a reset, a non-maskable interrupt or an interrupt as selected.
// [R7] The independent watchdog counts edges of its own 15 kHz oscillator, not of the system clock.
// [R8] The independent watchdog starts by itself after reset, underflow or refresh error, or on its first refresh.
// [R9] A refresh outside the permitted window is a refresh error and gets the same response as an underflow.
// [R10] Each watchdog keeps flags telling whether its last event was an underflow or a refresh error.
package watchdog_pkg;

    localparam int COUNT_WIDTH = 14;
    localparam logic [13:0] COUNT_RESET = 14'h0000;
    localparam logic [13:0] COUNT_MAX = 14'h3FFF;
    localparam int IWD_OSC_KHZ = 15;
    localparam int CLK_KHZ = 10000;
    // The 15 kHz oscillator is sampled by the 10 MHz clock, so each high phase spans many cycles.
    localparam int IWD_OSC_CYCLES = CLK_KHZ / IWD_OSC_KHZ;
    localparam int WWD_DIV_DEFAULT = 4;
    localparam logic [15:0] DIV_RESET = 16'h0000;

    typedef enum logic [1:0] {
        RESP_RESET = 2'h0,
        RESP_NMI   = 2'h1,
        RESP_IRQ   = 2'h3
    } response_t;

    typedef enum logic [1:0] {
        WD_STOPPED = 2'h0,
        WD_RUNNING = 2'h1
    } wd_state_t;

endpackage

/* File: watchdog_core.sv */
module watchdog_core #(
    parameter int WIDTH = watchdog_pkg::COUNT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic             tick,
    input  wire logic             refresh,
    input  wire logic             auto_start,
    input  wire logic [WIDTH-1:0] reload,
    input  wire logic [WIDTH-1:0] win_lo,
    input  wire logic [WIDTH-1:0] win_hi,
    input  wire logic [1:0]       response,
    input  wire logic             flag_clear,
    output logic                  running,
    output logic [WIDTH-1:0]      count,
    output logic                  reset_req,
    output logic                  nmi_req,
    output logic                  irq_req,
    output logic                  underflow_flag,
    output logic                  refresh_error_flag
);

    watchdog_pkg::wd_state_t state_reg;
    watchdog_pkg::wd_state_t state_next;
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             rst_reg;
    logic             nmi_reg;
    logic             irq_reg;
    logic             ufl_flag_reg;
    logic             err_flag_reg;

    wire is_running  = (state_reg == watchdog_pkg::WD_RUNNING);
    wire in_window   = (count_reg >= win_lo) && (count_reg <= win_hi);
    wire refresh_ok  = is_running && refresh && in_window;                   // [R4]
    wire refresh_bad = is_running && refresh && !in_window;                  // [R9]
    wire underflow   = is_running && !refresh && tick && (count_reg == '0);
    wire fault       = underflow || refresh_bad;
    wire start_now   = !is_running && (refresh || auto_start);               // [R8]
    wire sel_reset   = fault && (response == watchdog_pkg::RESP_RESET);      // [R2] [R6]
    wire sel_nmi     = fault && (response == watchdog_pkg::RESP_NMI);        // [R3] [R6]
    wire sel_irq     = fault && (response == watchdog_pkg::RESP_IRQ);        // [R3] [R6]

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            watchdog_pkg::WD_STOPPED: begin
                if (start_now) begin
                    state_next = watchdog_pkg::WD_RUNNING;
                    count_next = reload;
                end
            end
            watchdog_pkg::WD_RUNNING: begin
                if (fault) begin
                    // Without auto start the counter waits for software to refresh it again.
                    count_next = reload;
                    state_next = auto_start ? watchdog_pkg::WD_RUNNING : watchdog_pkg::WD_STOPPED; // [R8]
                end else if (refresh_ok) begin
                    count_next = reload; // [R1]
                end else if (tick) begin
                    count_next = count_reg - 1'b1; // [R1]
                end
            end
            default: begin
                state_next = watchdog_pkg::WD_STOPPED;
                count_next = reload;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= watchdog_pkg::WD_STOPPED;
            count_reg <= watchdog_pkg::COUNT_RESET;
            rst_reg   <= 1'b0;
            nmi_reg   <= 1'b0;
            irq_reg   <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            count_reg <= count_next;
            rst_reg   <= sel_reset;
            nmi_reg   <= sel_nmi;
            irq_reg   <= sel_irq;
        end
    end

    // A new event wins over a clear in the same cycle; the other flag drops so the last event is kept.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ufl_flag_reg <= 1'b0;
            err_flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (fault) begin
                ufl_flag_reg <= underflow; // [R10]
                err_flag_reg <= refresh_bad; // [R10]
            end else if (flag_clear) begin
                ufl_flag_reg <= 1'b0;
                err_flag_reg <= 1'b0;
            end
        end
    end

    assign running            = is_running;
    assign count              = count_reg;
    assign reset_req          = rst_reg;
    assign nmi_req            = nmi_reg;
    assign irq_req            = irq_reg;
    assign underflow_flag     = ufl_flag_reg;
    assign refresh_error_flag = err_flag_reg;

endmodule // watchdog_core

/* File: dual_watchdog_timers.sv */
module dual_watchdog_timers #(
    parameter int WWD_DIV = watchdog_pkg::WWD_DIV_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        iwd_osc,
    input  wire logic        wwd_refresh,
    input  wire logic        wwd_auto_start,
    input  wire logic [13:0] wwd_reload,
    input  wire logic [13:0] wwd_win_lo,
    input  wire logic [13:0] wwd_win_hi,
    input  wire logic [1:0]  wwd_response,
    input  wire logic        wwd_flag_clear,
    input  wire logic        iwd_refresh,
    input  wire logic        iwd_auto_start,
    input  wire logic [13:0] iwd_reload,
    input  wire logic [1:0]  iwd_response,
    input  wire logic        iwd_flag_clear,
    output logic             chip_reset_req,
    output logic             nmi_req,
    output logic             irq_req,
    output logic             wwd_running,
    output logic [13:0]      wwd_count,
    output logic             wwd_underflow_flag,
    output logic             wwd_refresh_error_flag,
    output logic             iwd_running,
    output logic [13:0]      iwd_count,
    output logic             iwd_underflow_flag,
    output logic             iwd_refresh_error_flag
);

    localparam logic [15:0] DIV_LAST = 16'(WWD_DIV - 1);

    logic [15:0] div_reg;
    logic        osc_prev_reg;
    logic        rst_out_reg;
    logic        nmi_out_reg;
    logic        irq_out_reg;
    logic        w_rst;
    logic        w_nmi;
    logic        w_irq;
    logic        i_rst;
    logic        i_nmi;
    logic        i_irq;

    wire wwd_tick = (div_reg == DIV_LAST);
    // The independent count follows oscillator edges, which are only seen on clk edges with clk_en high.
    wire iwd_tick = iwd_osc && !osc_prev_reg; // [R7]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_reg      <= watchdog_pkg::DIV_RESET;
            osc_prev_reg <= 1'b0;
            rst_out_reg  <= 1'b0;
            nmi_out_reg  <= 1'b0;
            irq_out_reg  <= 1'b0;
        end else if (clk_en) begin
            div_reg      <= wwd_tick ? watchdog_pkg::DIV_RESET : div_reg + 16'h0001;
            osc_prev_reg <= iwd_osc;
            rst_out_reg  <= w_rst || i_rst; // [R2] [R6]
            nmi_out_reg  <= w_nmi || i_nmi; // [R3] [R6]
            irq_out_reg  <= w_irq || i_irq; // [R3] [R6]
        end
    end

    watchdog_core #(.WIDTH(watchdog_pkg::COUNT_WIDTH)) window_watchdog (
        .clk                (clk),
        .reset_n            (reset_n),
        .clk_en             (clk_en),
        .tick               (wwd_tick),
        .refresh            (wwd_refresh),
        .auto_start         (wwd_auto_start),
        .reload             (wwd_reload),
        .win_lo             (wwd_win_lo),
        .win_hi             (wwd_win_hi),
        .response           (wwd_response),
        .flag_clear         (wwd_flag_clear),
        .running            (wwd_running),
        .count              (wwd_count),
        .reset_req          (w_rst),
        .nmi_req            (w_nmi),
        .irq_req            (w_irq),
        .underflow_flag     (wwd_underflow_flag),
        .refresh_error_flag (wwd_refresh_error_flag)
    );

    // The independent watchdog has no window, so any refresh while running is accepted.
    watchdog_core #(.WIDTH(watchdog_pkg::COUNT_WIDTH)) independent_watchdog (
        .clk                (clk),
        .reset_n            (reset_n),
        .clk_en             (clk_en),
        .tick               (iwd_tick),
        .refresh            (iwd_refresh),
        .auto_start         (iwd_auto_start),
        .reload             (iwd_reload),
        .win_lo             (watchdog_pkg::COUNT_RESET),
        .win_hi             (watchdog_pkg::COUNT_MAX),
        .response           (iwd_response),
        .flag_clear         (iwd_flag_clear),
        .running            (iwd_running),
        .count              (iwd_count),
        .reset_req          (i_rst),
        .nmi_req            (i_nmi),
        .irq_req            (i_irq),
        .underflow_flag     (iwd_underflow_flag),
        .refresh_error_flag (iwd_refresh_error_flag)
    );

    assign chip_reset_req = rst_out_reg;
    assign nmi_req        = nmi_out_reg;
    assign irq_req        = irq_out_reg;

endmodule // dual_watchdog_timers

/* File: dual_watchdog_timers_props.sv */
module watchdog_props #(
    parameter int WWD_DIV = watchdog_pkg::WWD_DIV_DEFAULT
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        iwd_osc,
    input wire logic        wwd_refresh,
    input wire logic        iwd_refresh,
    input wire logic [13:0] wwd_win_lo,
    input wire logic [13:0] wwd_win_hi,
    input wire logic [1:0]  wwd_response,
    input wire logic        chip_reset_req,
    input wire logic        nmi_req,
    input wire logic        irq_req,
    input wire logic        wwd_running,
    input wire logic [13:0] wwd_count,
    input wire logic        wwd_underflow_flag,
    input wire logic        wwd_refresh_error_flag,
    input wire logic        iwd_running,
    input wire logic [13:0] iwd_count
);
    logic osc_q_reg;
    // The window tick relations below only hold when the window divider passes every cycle.
    wire uf  = WWD_DIV == 1 && wwd_running && clk_en && !wwd_refresh && wwd_count == 14'h0000;
    wire bad = wwd_running && clk_en && wwd_refresh && (wwd_count < wwd_win_lo || wwd_count > wwd_win_hi);
    wire rise = clk_en && iwd_running && !iwd_refresh && iwd_osc && !osc_q_reg;
    // Mirrors the edge detector in the design, whose reset does not wait for the clock enable.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            osc_q_reg <= 1'b0;
        end else if (clk_en) begin
            osc_q_reg <= iwd_osc;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_reset_clears: assert property (disable iff (1'b0)
        !reset_n && clk_en |=> !wwd_running && !iwd_running && wwd_count == 14'h0000 && !chip_reset_req)
        else $error("reset left state");
    a_wwd_counts_down: assert property (
        WWD_DIV == 1 && wwd_running && clk_en && !wwd_refresh && wwd_count != 14'h0000
        |=> wwd_count == $past(wwd_count) - 14'h0001) else $error("window count step");
    a_wwd_underflow_flag: assert property (
        uf |=> wwd_underflow_flag && !wwd_refresh_error_flag) else $error("underflow flag wrong");
    a_bad_refresh_flag: assert property (
        bad |=> wwd_refresh_error_flag && !wwd_underflow_flag) else $error("refresh error flag wrong");
    a_reset_response: assert property (
        (uf || bad) && wwd_response == watchdog_pkg::RESP_RESET |=> ##1 chip_reset_req)
        else $error("no reset request");
    a_nmi_response: assert property (
        (uf || bad) && wwd_response == watchdog_pkg::RESP_NMI |=> ##1 nmi_req)
        else $error("no nmi request");
    a_irq_response: assert property (
        (uf || bad) && wwd_response == watchdog_pkg::RESP_IRQ |=> ##1 irq_req)
        else $error("no irq request");
    a_iwd_osc_tick: assert property (
        rise && iwd_count != 14'h0000 |=> iwd_count == $past(iwd_count) - 14'h0001)
        else $error("independent count step");
    a_iwd_holds: assert property (
        clk_en && iwd_running && !iwd_refresh && !(iwd_osc && !osc_q_reg) |=> $stable(iwd_count))
        else $error("independent count moved");
endmodule // watchdog_props

/* File: dual_watchdog_timers_bench.sv */
module dual_watchdog_timers_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [1:0] resp; logic [13:0] reload; logic [2:0] pulses;} row_t;
    logic        clk, reset_n, clk_en, iwd_osc, wwd_refresh, wwd_auto_start, wwd_flag_clear;
    logic        iwd_refresh, iwd_auto_start, iwd_flag_clear, chip_reset_req, nmi_req, irq_req;
    logic        wwd_running, wwd_underflow_flag, wwd_refresh_error_flag;
    logic        iwd_running, iwd_underflow_flag, iwd_refresh_error_flag;
    logic [1:0]  wwd_response, iwd_response;
    logic [13:0] wwd_reload, wwd_win_lo, wwd_win_hi, iwd_reload, wwd_count, iwd_count;
    int          n_errors = 0;
    int          total_checks = 0;
    int          n;
    row_t        rows [4] = '{'{2'h0, 14'h0003, 3'h4}, '{2'h1, 14'h0000, 3'h2},
                              '{2'h3, 14'h0007, 3'h1}, '{2'h2, 14'h0001, 3'h0}};
    dual_watchdog_timers #(.WWD_DIV(1)) dut (.*);
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_req(int lim);
        n = 1;
        while ({chip_reset_req, nmi_req, irq_req} === 3'h0 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic pulse_wwd();
        wwd_refresh = 1'b1;
        @(negedge clk);
        wwd_refresh = 1'b0;
    endtask
    task automatic osc_edge();
        iwd_osc = 1'b1;
        @(negedge clk);
        iwd_osc = 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(100 * 3000);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {reset_n, iwd_osc, wwd_refresh, wwd_auto_start, wwd_flag_clear} = 5'h00;
        {iwd_refresh, iwd_auto_start, iwd_flag_clear, wwd_win_lo} = 17'h00000;
        {clk_en, wwd_win_hi, iwd_reload, wwd_reload} = {1'b1, 14'h3FFF, 14'h0002, 14'h0000};
        {wwd_response, iwd_response} = 4'h0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        check("idle", {wwd_running, iwd_running, wwd_count}, 16'h0000);
        check("idle_req", {13'h0000, chip_reset_req, nmi_req, irq_req}, 16'h0000);
        foreach (rows[i]) begin
            wwd_response = rows[i].resp;
            wwd_reload = rows[i].reload;
            pulse_wwd();
            wait_req(40);
            check("pulses", {13'h0000, chip_reset_req, nmi_req, irq_req}, {13'h0000, rows[i].pulses});
            check("delay", 16'(n), (rows[i].pulses != 3'h0) ? 16'(rows[i].reload) + 16'h0003 : 16'h0028);
            check("uf_flag", {wwd_underflow_flag, wwd_running, wwd_count}, {2'h2, rows[i].reload});
            wwd_flag_clear = 1'b1;
            @(negedge clk);
            wwd_flag_clear = 1'b0;
            check("uf_clear", {wwd_underflow_flag, wwd_refresh_error_flag}, 16'h0000);
        end
        // A refresh inside the window reloads quietly; an early one right after is a fault.
        {wwd_reload, wwd_win_hi, wwd_response} = {14'h000A, 14'h0005, 2'h3};
        pulse_wwd();
        repeat (6) @(negedge clk);
        pulse_wwd();
        check("good_refresh", {wwd_refresh_error_flag, wwd_count}, 16'h000A);
        pulse_wwd();
        check("bad_refresh", {wwd_refresh_error_flag, wwd_underflow_flag, wwd_count}, 16'h800A);
        wait_req(5);
        check("bad_pulse", {13'h0000, chip_reset_req, nmi_req, irq_req}, 16'h0001);
        check("bad_delay", 16'(n), 16'h0002);
        iwd_response = 2'h1;
        iwd_refresh = 1'b1;
        @(negedge clk);
        iwd_refresh = 1'b0;
        check("iwd_start", {iwd_running, iwd_count}, 16'h4002);
        repeat (5) @(negedge clk);
        check("iwd_idle", iwd_count, 16'h0002);
        osc_edge();
        check("iwd_tick", iwd_count, 16'h0001);
        osc_edge();
        osc_edge();
        wait_req(4);
        check("iwd_pulse", {13'h0000, chip_reset_req, nmi_req, irq_req}, 16'h0002);
        check("iwd_flag", {iwd_underflow_flag, iwd_refresh_error_flag}, 16'h0002);
        iwd_flag_clear = 1'b1;
        @(negedge clk);
        iwd_flag_clear = 1'b0;
        check("iwd_clear", {iwd_underflow_flag, iwd_refresh_error_flag}, 16'h0000);
        iwd_auto_start = 1'b1;
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check("iwd_auto", {iwd_running, iwd_count}, 16'h4002);
        // Software services the independent counter two ticks before it would run out.
        osc_edge();
        iwd_refresh = 1'b1;
        @(negedge clk);
        iwd_refresh = 1'b0;
        check("iwd_keep", {iwd_running, iwd_count}, 16'h4002);
        check("iwd_quiet", {iwd_underflow_flag, iwd_refresh_error_flag, chip_reset_req, nmi_req, irq_req}, 16'h0000);
        // With auto start the window counter restarts by itself and keeps running through a fault.
        wwd_auto_start = 1'b1;
        repeat (2) @(negedge clk);
        check("wwd_auto_run", {wwd_running, wwd_count}, 16'h4009);
        wait_req(20);
        check("wwd_auto_irq", {12'h000, wwd_running, chip_reset_req, nmi_req, irq_req}, 16'h0009);
        check("wwd_auto_delay", 16'(n), 16'h000C);
        tally_and_finish();
    end
endmodule // dual_watchdog_timers_bench
bind dual_watchdog_timers watchdog_props #(.WWD_DIV(WWD_DIV)) u_props (.clk, .reset_n, .clk_en, .iwd_osc,
    .wwd_refresh, .iwd_refresh, .wwd_win_lo, .wwd_win_hi, .wwd_response, .chip_reset_req, .nmi_req, .irq_req,
    .wwd_running, .wwd_count, .wwd_underflow_flag, .wwd_refresh_error_flag, .iwd_running, .iwd_count);
